/* File: hw/spsd_pkg.sv */
// Package for the serial peripheral block: register map, field positions,
// reset values, clock divider figures and the shared types.
// Assumes a byte-wide register port and a 100 MHz system clock.
package spsd_pkg;

  // ****************************************************************
  // Register map and field positions
  // ****************************************************************
  localparam logic [7:0] SPSD_DATA_ADDR = 8'h86;
  localparam logic [7:0] SPSD_STAT_ADDR = 8'haa;
  localparam logic [7:0] SPSD_CTRL_ADDR = 8'hd5;

  localparam int SPSD_STAT_DONE  = 7;
  localparam int SPSD_STAT_COLL  = 6;
  localparam int SPSD_STAT_LDW   = 5;
  localparam int SPSD_STAT_SLAVE_OUTPUT_DISABLE = 1;
  localparam int SPSD_STAT_ENH   = 0;

  localparam logic [7:0] SPSD_CTRL_RST = 8'h00;
  localparam logic [7:0] SPSD_DATA_RST = 8'h00;
  localparam logic [7:0] SPSD_RD_IDLE  = 8'h00;

  // ****************************************************************
  // Serial clock figures
  // ****************************************************************
  // Master clock divides for rate codes 00, 01, 10 and 11.
  localparam int SPSD_DIV0 = 4;
  localparam int SPSD_DIV1 = 8;
  localparam int SPSD_DIV2 = 32;
  localparam int SPSD_DIV3 = 64;
  localparam int SPSD_HALF_W = 6;
  // A byte is sixteen clock edges; the last one has this index.
  localparam logic [3:0] SPSD_LAST_EDGE = 4'hf;
  // Two-flop sync of pins needs at least this many system clocks per half.
  localparam int SPSD_SLV_MIN_HALF = 3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic       serial_irq_enable;
    logic       serial_port_enable;
    logic       bit_order_select;
    logic       master_role_select;
    logic       clock_idle_polarity;
    logic       clock_sample_phase;
    logic [1:0] clock_rate_select;
  } spsd_ctl_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } spsd_pins_t;

  typedef enum logic {
    SPSD_IDLE = 1'b0,
    SPSD_RUN  = 1'b1
  } spsd_state_t;

endpackage

/* File: hw/spsd_sync.sv */
// Two flip-flop synchroniser for pin inputs, one stage pair per bit.
// Assumes the inputs are asynchronous to clock; only stage two is read.
`timescale 1ns/10ps
module spsd_sync #(
  parameter int              W       = 4,
  parameter logic [W-1:0]    RST_VAL = '1
) (
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Asynchronous inputs and their synchronised copies.
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // Both stages take the idle value under reset.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

/* File: hw/spsd_top.sv */
// Serial peripheral block: status, data, transmit buffer, clock generator
// and pin drive for master and slave roles.
// Assumes a byte register port with one-cycle strobes and pins that are
// joined to pads by the surroundings from the output enables.
//
// Notes on behaviour
// RULE1 - Done flag sets when a byte completes.
// RULE2 - Interrupt needs done, port and group enables.
// RULE3 - Status read then data access clears done.
// RULE4 - Normal mode: busy write sets collision.
// RULE5 - Normal mode: busy write is dropped.
// RULE6 - Normal mode: collision clears with done.
// RULE7 - Double mode: flag means buffer full; overwrite.
// RULE8 - Double mode: full clears only on unload.
// RULE9 - Load window high in slots 0-3.
// RULE10 - Software loads when window high, not full.
// RULE11 - Output disable floats the slave output.
// RULE12 - Only the addressed slave enables its output.
// RULE13 - Mode bit picks single or double buffering.
// RULE14 - Buffer shares the data register address.
// RULE15 - Data register cold resets, warm keeps.
// RULE16 - Master: rate bits pick four rates.
// RULE17 - Slave follows incoming clock within limits.
// RULE18 - Phase and polarity pick four formats.
// RULE19 - Configure format before enabling, master first.
// RULE20 - Master pin setup is software's job.
// RULE21 - Slave pin setup is software's job.
// RULE22 - Role switch needs no pin change.
// RULE23 - Master rate is clock over 4/8/32/64.
// RULE24 - Clock idles at the polarity bit.
// RULE25 - Full buffer at end continues without pause.
// RULE26 - Phase zero samples leading, else trailing.
`timescale 1ns/10ps
module spsd_top
  import spsd_pkg::*;
(
  // Clock and resets; cold reset also clears the data register.
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       cold_rst_n,
  // Register port.
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Interrupt group enable in and request out.
  input  wire logic       serial_group_irq_enable,
  output logic            spi_irq,
  // Serial clock pin.
  input  wire logic       sck_i,
  output logic            sck_o,
  output logic            sck_oe,
  // Master-out pin.
  input  wire logic       mosi_i,
  output logic            mosi_o,
  output logic            mosi_oe,
  // Master-in pin.
  input  wire logic       miso_i,
  output logic            miso_o,
  output logic            miso_oe,
  // Slave select pin.
  input  wire logic       ss_n_i
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  spsd_ctl_t          ctl_q;
  spsd_state_t        state_q;
  spsd_pins_t         pin_s;
  logic               done_q;
  logic               coll_q;
  logic               arm_q;
  logic               slave_output_disable_q;
  logic               enh_q;
  logic [7:0]         buf_q;
  logic [7:0]         sr_q;
  logic [7:0]         rx_q;
  logic               out_q;
  logic [3:0]         edge_q;
  logic [SPSD_HALF_W-1:0] div_q;
  logic               sck_prev_q;
  logic               smp_q;
  logic               done_p_q;
  logic [7:0]         rxs_q;

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  spsd_sync #(
    .W       (4),
    .RST_VAL (4'hf)
  ) u_sync (
    .clock   (clock),
    .rst_n   (rst_n),
    .async_i ({sck_i, mosi_i, miso_i, ss_n_i}),
    .sync_o  (pin_s)
  );

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire wr_data = reg_wr && (reg_addr == SPSD_DATA_ADDR);
  wire rd_data = reg_rd && (reg_addr == SPSD_DATA_ADDR);
  wire wr_stat = reg_wr && (reg_addr == SPSD_STAT_ADDR);
  wire rd_stat = reg_rd && (reg_addr == SPSD_STAT_ADDR);
  wire wr_ctrl = reg_wr && (reg_addr == SPSD_CTRL_ADDR);
  wire mst     = ctl_q.master_role_select;
  wire en      = ctl_q.serial_port_enable;

  // ****************************************************************
  // Clock edges
  // ****************************************************************
  // Master half period follows the rate code; slave takes pin edges.
  wire [SPSD_HALF_W-1:0] half =
    (ctl_q.clock_rate_select == 2'b00) ? SPSD_HALF_W'(SPSD_DIV0 / 2 - 1) : // RULE23
    (ctl_q.clock_rate_select == 2'b01) ? SPSD_HALF_W'(SPSD_DIV1 / 2 - 1) :
    (ctl_q.clock_rate_select == 2'b10) ? SPSD_HALF_W'(SPSD_DIV2 / 2 - 1) :
                           SPSD_HALF_W'(SPSD_DIV3 / 2 - 1);
  wire run    = (state_q == SPSD_RUN);
  wire m_edge = en && mst && run && (div_q == half); // RULE16
  wire s_edge = en && !mst && !pin_s.ss_n &&
                (pin_s.sck != sck_prev_q);           // RULE17
  wire edg    = m_edge || s_edge;
  wire lead   = !edge_q[0];
  // Sampling edge is leading for phase zero, trailing for phase one.
  wire smp    = edg && (lead ^ ctl_q.clock_sample_phase);  // RULE26 RULE18
  wire chg    = edg && !(lead ^ ctl_q.clock_sample_phase); // RULE26
  wire done   = edg && (edge_q == SPSD_LAST_EDGE);
  wire active = mst ? run : !pin_s.ss_n;
  wire busy   = mst ? run : (edge_q != 4'h0);

  // ****************************************************************
  // Shift path and buffer moves
  // ****************************************************************
  wire       rx_in    = mst ? pin_s.miso : pin_s.mosi;
  wire [7:0] sr_shift = ctl_q.bit_order_select ? {rx_in, sr_q[7:1]} :
                                     {sr_q[6:0], rx_in};
  wire       wr_load  = wr_data && !busy;
  wire       wr_buf   = wr_data && busy && enh_q;            // RULE14
  wire       coll_evt = wr_data && busy && !enh_q;           // RULE4
  wire       buf_load = done && enh_q && (coll_q || wr_buf); // RULE25
  wire       ld       = wr_load || buf_load;
  wire [7:0] ld_val   = (wr_load || wr_buf) ? reg_wdata : buf_q;
  wire       ld_top   = ctl_q.bit_order_select ? ld_val[0] : ld_val[7];
  wire       sr_top   = ctl_q.bit_order_select ? sr_q[0] : sr_q[7];
  wire       clr_seq  = arm_q && (rd_data || wr_data);       // RULE3
  // A master input bit changed on the far side needs two synchroniser
  // clocks to arrive, so the master takes it one cycle after its edge.
  wire       rx_stb   = mst ? smp_q : smp;
  wire       rx_cap   = mst ? done_p_q : done;
  wire [7:0] rx_shift = ctl_q.bit_order_select ? {rx_in, rxs_q[7:1]} :
                                     {rxs_q[6:0], rx_in};

  // ****************************************************************
  // Status flag next values
  // ****************************************************************
  // A hardware set wins over a clear in the same cycle.
  wire done_d = done || (done_q && !clr_seq); // RULE1 RULE3
  wire coll_set = coll_evt || (wr_buf && !buf_load); // RULE4 RULE7
  wire coll_clr = enh_q ? buf_load : clr_seq;        // RULE6 RULE8
  wire coll_d   = coll_set || (coll_q && !coll_clr);
  wire ldw      = active && !edge_q[3];              // RULE9
  wire [7:0] stat_v = {done_q, coll_q, ldw, 3'b000, slave_output_disable_q, enh_q};
  wire [7:0] rd_mux =
    (reg_addr == SPSD_DATA_ADDR) ? rx_q :
    (reg_addr == SPSD_STAT_ADDR) ? stat_v :
    (reg_addr == SPSD_CTRL_ADDR) ? ctl_q :
                                   SPSD_RD_IDLE;

  // ****************************************************************
  // Control and status registers
  // ****************************************************************
  // Software-written bits and the sticky flags.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctl_q   <= SPSD_CTRL_RST;
      slave_output_disable_q <= 1'b0;
      enh_q   <= 1'b0;
      done_q  <= 1'b0;
      coll_q  <= 1'b0;
      arm_q   <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctl_q <= reg_wdata;
      end
      if (wr_stat) begin
        slave_output_disable_q <= reg_wdata[SPSD_STAT_SLAVE_OUTPUT_DISABLE];
        enh_q   <= reg_wdata[SPSD_STAT_ENH]; // RULE13
      end
      done_q <= done_d;
      coll_q <= coll_d;
      if (rd_stat) begin
        arm_q <= 1'b1;
      end else if (rd_data || wr_data) begin
        arm_q <= 1'b0;
      end
    end
  end

  // Read data stand for the one cycle after the strobe.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= SPSD_RD_IDLE;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : SPSD_RD_IDLE;
    end
  end

  // ****************************************************************
  // Data path registers
  // ****************************************************************
  // Shift and receive registers survive a warm reset.
  always_ff @(posedge clock) begin
    if (!cold_rst_n) begin
      sr_q  <= SPSD_DATA_RST; // RULE15
      rx_q  <= SPSD_DATA_RST;
      rxs_q <= SPSD_DATA_RST;
    end else begin
      if (ld) begin
        sr_q <= ld_val;
      end else if (smp) begin
        sr_q <= sr_shift;
      end
      if (rx_stb) begin
        rxs_q <= rx_shift; // RULE26
      end
      if (rx_cap) begin
        rx_q <= rx_stb ? rx_shift : rxs_q;
      end
    end
  end

  // Buffer byte; a write while full replaces it.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      buf_q <= SPSD_DATA_RST;
    end else if (wr_buf) begin
      buf_q <= reg_wdata; // RULE7
    end
  end

  // Output bit: set by a load, advanced on each changing edge.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_q <= 1'b0;
    end else if (ld) begin
      out_q <= ld_top;
    end else if (chg) begin
      out_q <= sr_top; // RULE26
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Master run state; a full buffer keeps the clock going.
  always_ff @(posedge clock) begin
    if (!rst_n || !en) begin
      state_q <= SPSD_IDLE;
    end else if (!mst) begin
      state_q <= SPSD_IDLE;
    end else if (wr_load) begin
      state_q <= SPSD_RUN;
    end else if (done && !buf_load) begin
      state_q <= SPSD_IDLE; // RULE25
    end
  end

  // Divider and edge count; slave count restarts with select high.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_q      <= '0;
      edge_q     <= 4'h0;
      sck_prev_q <= 1'b1;
      smp_q      <= 1'b0;
      done_p_q   <= 1'b0;
    end else begin
      sck_prev_q <= pin_s.sck;
      smp_q      <= smp;
      done_p_q   <= done;
      div_q      <= (!run || m_edge) ? '0 : div_q + 1'b1;
      if (!en || (mst && !run) || (!mst && pin_s.ss_n)) begin
        edge_q <= 4'h0;
      end else if (edg) begin
        edge_q <= edge_q + 4'h1;
      end
    end
  end

  // ****************************************************************
  // Pins and request
  // ****************************************************************
  // Enables swap with the role bit alone, so pins need no change.
  assign sck_o   = ctl_q.clock_idle_polarity ^ edge_q[0];          // RULE24
  assign sck_oe  = en && mst;                       // RULE22
  assign mosi_o  = out_q;
  assign mosi_oe = en && mst;
  assign miso_o  = out_q;
  assign miso_oe = en && !mst && !pin_s.ss_n && !slave_output_disable_q; // RULE11
  assign spi_irq = done_q && ctl_q.serial_irq_enable &&
                   serial_group_irq_enable;         // RULE2

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n || !cold_rst_n);

  a_done_sets: assert property (done |=> done_q) // RULE1
    else $error("done flag not set after byte end");
  a_irq_gate: assert property (spi_irq |-> done_q && ctl_q.serial_irq_enable && serial_group_irq_enable) // RULE2
    else $error("interrupt without flag or enable");
  a_done_clear: assert property ($fell(done_q) |-> $past(clr_seq)) // RULE3
    else $error("done flag cleared without sequence");
  a_coll_normal: assert property (wr_data && busy && !enh_q |=> coll_q) // RULE4
    else $error("collision not flagged");
  a_write_drop: assert property (coll_evt && !smp |=> $stable(sr_q)) // RULE5
    else $error("busy write reached shift register");
  a_full_hold: assert property ($fell(coll_q) && $past(enh_q) |-> $past(buf_load)) // RULE8
    else $error("buffer full cleared without unload");
  a_load_window: assert property (active && edge_q >= 4'h8 |-> !ldw) // RULE9
    else $error("load window high late in byte");
  a_slave_float: assert property (slave_output_disable_q |-> !miso_oe) // RULE11
    else $error("slave output driven while disabled");
  a_rate_div4: assert property (m_edge && ctl_q.clock_rate_select == 2'b00 && edge_q != SPSD_LAST_EDGE && !wr_ctrl |=> !m_edge ##1 m_edge) // RULE23
    else $error("wrong master clock rate");
  a_idle_level: assert property (en && mst && !run |-> sck_o == ctl_q.clock_idle_polarity) // RULE24
    else $error("serial clock not at idle level");
  a_continue: assert property (done && mst && enh_q && coll_q |=> run && !coll_q) // RULE25
    else $error("buffered byte did not continue");

  c_normal_byte: cover property (done && !enh_q);
  c_buffer_chain: cover property (buf_load && mst);
  c_collision: cover property (coll_evt);
  c_slave_byte: cover property (done && !mst);

endmodule

/* File: dv/spsd_peer.sv */
// Far-side serial device model: takes the master output bits and returns
// a fixed byte on the master input, in any clock phase.
// Assumes the bench selects it around each frame.
`timescale 1ns/10ps
module spsd_peer (
  // Serial lines and phase.
  input  wire logic        sck,
  input  wire logic        mosi,
  input  wire logic        sel_n,
  input  wire logic        clock_sample_phase,
  // Byte returned and bits taken.
  input  wire logic [7:0]  tx,
  output logic             miso,
  output logic      [15:0] rx
);
  int   n    = 0;
  int   k;
  logic last = 1'b0;
  // Edge count restarts with each frame.
  always @(negedge sel_n) n = 0;
  // Phase zero samples on odd edges, phase one on even edges.
  always @(sck) begin
    if (!sel_n) begin
      n = n + 1;
      if (n[0] ^ clock_sample_phase) rx = {rx[14:0], mosi};
    end
  end
  // The output bit moves on the other edge; a released line is inverted.
  assign k    = (clock_sample_phase && n > 0) ? (n - 1) / 2 : n / 2;
  assign miso = sel_n ? ~last : tx[7 - (k % 8)];
  always @(miso) if (!sel_n) last = miso;
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the serial block in master and slave roles.
// Assumes the package map and one far-side model on the serial lines.
`timescale 1ns/10ps
module testbench
  import spsd_pkg::*;
;
  logic        clock, rst_n, cold_rst_n, reg_wr, reg_rd, grp_en;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_val, peer_tx;
  logic        spi_irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic        tb_sck, tb_ss_n, peer_sel_n, clock_sample_phase_now, peer_miso, sck_prev;
  logic [15:0] peer_rx;
  int          fails = 0, tests_run = 0, cyc = 0;
  int          lead_q[$];
  int          divs[4] = '{SPSD_DIV0, SPSD_DIV1, SPSD_DIV2, SPSD_DIV3};
  // Pin levels from the block's output enables.
  wire sck_pin  = sck_oe ? sck_o : tb_sck;
  wire mosi_pin = mosi_oe ? mosi_o : 1'b1;
  wire miso_pin = miso_oe ? miso_o : peer_miso;

  spsd_top DUT (
    .clock(clock), .rst_n(rst_n), .cold_rst_n(cold_rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_group_irq_enable(grp_en), .spi_irq(spi_irq),
    .sck_i(sck_pin), .sck_o(sck_o), .sck_oe(sck_oe),
    .mosi_i(mosi_pin), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_i(miso_pin), .miso_o(miso_o), .miso_oe(miso_oe),
    .ss_n_i(tb_ss_n)
  );
  spsd_peer peer (
    .sck(sck_pin), .mosi(mosi_pin), .sel_n(peer_sel_n),
    .clock_sample_phase(clock_sample_phase_now), .tx(peer_tx), .miso(peer_miso), .rx(peer_rx)
  );

  // ****************************************************************
  // Clock, cycle count and leading clock edges
  // ****************************************************************
  // The clock toggles every 5 ns.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Leading edges are moves of the pin away from its idle level.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    sck_prev <= sck_pin;
    if (sck_pin !== sck_prev && sck_pin !== tb_sck) lead_q.push_back(cyc);
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Compares and counts; a mismatch prints one line.
  task automatic chk(input string nm, input logic [15:0] exp, got);
    tests_run++;
    if (exp !== got) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One-cycle register write.
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // One-cycle register read; data taken in the following cycle.
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  // Warm reset alone, or warm and cold together, for 5 cycles.
  task automatic do_reset(input logic cold);
    @(posedge clock);
    rst_n <= 1'b0;
    cold_rst_n <= ~cold;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    cold_rst_n <= 1'b1;
  endtask
  // Polls the status register until the done flag shows.
  task automatic wait_done;
    int i = 0;
    do begin
      rd(SPSD_STAT_ADDR);
      i++;
    end while (rd_val[SPSD_STAT_DONE] !== 1'b1 && i < 400);
    chk("done flag", 1, rd_val[SPSD_STAT_DONE]);
  endtask
  // Sets the format with the port off, enables it, then starts a byte.
  task automatic xfer(input logic [7:0] ctl, b);
    tb_sck <= ctl[3];
    clock_sample_phase_now <= ctl[2];
    wr(SPSD_CTRL_ADDR, ctl & 8'hbf);
    wr(SPSD_CTRL_ADDR, ctl);
    #1 chk("sck idle", ctl[3], sck_pin);
    @(posedge clock) peer_sel_n <= 1'b0;
    lead_q.delete();
    wr(SPSD_DATA_ADDR, b);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("Checks run: %0d, mismatches: %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ****************************************************************
  // Watchdog and main sequence
  // ****************************************************************
  // A hang is cut short well beyond the expected length.
  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    give_verdict;
  end
  // Scenarios run in order.
  initial begin
    {reg_wr, reg_rd, grp_en, tb_sck, clock_sample_phase_now, sck_prev} = 6'h00;
    {rst_n, cold_rst_n, tb_ss_n, peer_sel_n} = 4'h3;
    {reg_addr, reg_wdata, peer_tx} = 24'h000000;
    do_reset(1'b1);
    rd(SPSD_STAT_ADDR);
    chk("status reset", 8'h00, rd_val);
    rd(8'h10);
    chk("unmapped", 8'h00, rd_val);
    rd(SPSD_DATA_ADDR);
    chk("data reset", 8'h00, rd_val);
    // Every rate code, each with a different phase and polarity pair.
    for (int r = 0; r < 4; r++) begin
      peer_tx <= 8'h3c ^ 8'(r);
      xfer({4'h5, r[0], r[1], r[1:0]}, 8'ha5 ^ 8'(r));
      wait_done;
      @(posedge clock) peer_sel_n <= 1'b1;
      chk("byte out", 8'ha5 ^ 8'(r), peer_rx[7:0]);
      chk("edge count", 16'h8, 16'(lead_q.size()));
      chk("period", 16'(divs[r]), 16'(lead_q[1] - lead_q[0]));
      rd(SPSD_DATA_ADDR);
      chk("byte in", 8'h3c ^ 8'(r), rd_val);
      rd(SPSD_STAT_ADDR);
      chk("done clear", 0, rd_val[SPSD_STAT_DONE]);
    end
    // Normal mode: busy write, load window, interrupt gating.
    peer_tx <= 8'h5a;
    xfer(8'hd3, 8'h81);
    rd(SPSD_STAT_ADDR);
    chk("window early", 3'b001, rd_val[7:5]);
    wr(SPSD_DATA_ADDR, 8'h7e);
    rd(SPSD_STAT_ADDR);
    chk("collision", 1, rd_val[SPSD_STAT_COLL]);
    for (int i = 0; i < 2000 && lead_q.size() < 5; i++) @(posedge clock);
    rd(SPSD_STAT_ADDR);
    chk("window late", 0, rd_val[SPSD_STAT_LDW]);
    wait_done;
    @(posedge clock) peer_sel_n <= 1'b1;
    chk("irq masked", 0, spi_irq);
    @(posedge clock) grp_en <= 1'b1;
    #1 chk("irq raised", 1, spi_irq);
    chk("write dropped", 8'h81, peer_rx[7:0]);
    rd(SPSD_DATA_ADDR);
    rd(SPSD_STAT_ADDR);
    chk("flags clear", 2'b00, rd_val[7:6]);
    chk("irq gone", 0, spi_irq);
    // Double mode: overwrite, kept flag, back-to-back bytes.
    wr(SPSD_STAT_ADDR, 8'h01);
    xfer(8'h51, 8'h11);
    rd(SPSD_STAT_ADDR);
    chk("load allowed", 3'b001, rd_val[7:5]);
    wr(SPSD_DATA_ADDR, 8'h22);
    wr(SPSD_DATA_ADDR, 8'h33);
    rd(SPSD_STAT_ADDR);
    chk("buffer full", 1, rd_val[SPSD_STAT_COLL]);
    rd(SPSD_DATA_ADDR);
    rd(SPSD_STAT_ADDR);
    chk("full kept", 1, rd_val[SPSD_STAT_COLL]);
    for (int i = 0; i < 1000 && lead_q.size() < 16; i++) @(posedge clock);
    wait_done;
    @(posedge clock) peer_sel_n <= 1'b1;
    chk("pair out", 16'h1133, peer_rx);
    chk("no gap", 16'(15 * SPSD_DIV1), 16'(lead_q[15] - lead_q[0]));
    chk("full gone", 0, rd_val[SPSD_STAT_COLL]);
    wr(SPSD_STAT_ADDR, 8'h00);
    // Slave role: output enable follows the disable bit.
    wr(SPSD_CTRL_ADDR, 8'h40);
    @(posedge clock) tb_ss_n <= 1'b0;
    repeat (4) @(posedge clock);
    #1 chk("slave drives", 1, miso_oe);
    wr(SPSD_STAT_ADDR, 8'h02);
    repeat (4) @(posedge clock);
    #1 chk("slave quiet", 0, miso_oe);
    rd(SPSD_STAT_ADDR);
    chk("disable bit", 8'ha2, rd_val);
    @(posedge clock) tb_ss_n <= 1'b1;
    // Warm reset keeps the data register, cold reset clears it.
    do_reset(1'b0);
    rd(SPSD_DATA_ADDR);
    chk("warm keeps", 8'h5a, rd_val);
    do_reset(1'b1);
    rd(SPSD_DATA_ADDR);
    chk("cold clears", 8'h00, rd_val);
    give_verdict;
  end
endmodule
